// ==== core/btk_map.vh ====
// address map, field positions and timing constants for the timekeeping sram clock
// What this block does
// - freeze bit (control bit 6) stops counter-to-visible transfers while it is one
// - while frozen, visible bytes keep the captured time; counters keep counting
// - on freeze clear, all visible bytes refresh together within one second
// - set bit (control bit 7) halts updates; clearing loads counters and resumes
// - seconds bit 7 stops the oscillator and all timekeeping
// - probe bit (day bit 6) toggles seconds bit 0 at 512 Hz while running
// - selects active and write strobe high gives a read; data driven only with drive enable
// - deselected device keeps data pins released whatever the other controls
// - reads ripple through; the data follows the address, registered on the next clock
// - write happens while strobe and both selects are active; address held stable
// - drive enable low before write strobe falls: read data then release
// - supply fail forces the select inactive, blocking all reads and writes
// - open-drain fail reset output held low while supply is below threshold
// - below battery level, counting and contents continue unchanged
// - battery stays disconnected until supply first rises above threshold
// - clock bytes sit at the eight highest addresses, accessed like ram
// - date rolls over by month length and leap year automatically
`ifndef BTK_MAP_VH
`define BTK_MAP_VH
`define BTK_ADDR_W 13
`define BTK_CTRL_ADDR 13'h1ff8
`define BTK_SEC_ADDR 13'h1ff9
`define BTK_MIN_ADDR 13'h1ffa
`define BTK_HOUR_ADDR 13'h1ffb
`define BTK_DAY_ADDR 13'h1ffc
`define BTK_DATE_ADDR 13'h1ffd
`define BTK_MONTH_ADDR 13'h1ffe
`define BTK_YEAR_ADDR 13'h1fff
`define BTK_CLK_AREA 10'h3ff
`define BTK_CTRL_SET_BIT 7
`define BTK_CTRL_FREEZE_BIT 6
`define BTK_STOP_BIT 7
`define BTK_PROBE_BIT 6
`define BTK_CLK_HZ 25000000
`define BTK_PROBE_HZ 1024
`define BTK_PROBE_DIV (`BTK_CLK_HZ / `BTK_PROBE_HZ)
`define BTK_SEC_DIV `BTK_CLK_HZ
`endif

// ==== core/btk_bcd_digit.v ====
// one bcd counter stage with programmable low and high wrap limits
`timescale 1ns/100ps
module btk_bcd_digit (
    // value
    input wire [7:0] cur,
    input wire [7:0] lo,
    input wire [7:0] hi,
    // result
    output reg [7:0] nxt,
    output reg carry
);
    always @* begin
        carry = 1'b0;
        if (cur >= hi) begin
            nxt = lo;
            carry = 1'b1;
        end else if (cur[3:0] == 4'h9) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = {cur[7:4], cur[3:0] + 4'h1};
        end
    end
endmodule // btk_bcd_digit

// ==== core/btk_clock_sram.v ====
// timekeeping static ram: 8k byte array, bcd counters and visible clock bytes
`timescale 1ns/100ps
`include "btk_map.vh"
module btk_clock_sram #(
    parameter SEC_DIV = `BTK_SEC_DIV,
    parameter PROBE_DIV = `BTK_PROBE_DIV
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // host sram port
    input wire [12:0] addr,
    input wire sel_b,
    input wire select_hi,
    input wire out_en_b,
    input wire wr_b,
    input wire [7:0] dq_in,
    output reg [7:0] dq_out,
    output reg dq_oe_b,
    // supply monitor
    input wire below_fail_threshold,
    input wire below_battery,
    // power-fail reset, open drain
    output reg fail_rst_out,
    output reg fail_rst_oe_b,
    // battery switch
    output reg battery_connect,
    output reg on_battery
);
    reg rs1_reg, rs2_reg;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end
    wire rst_n = rs2_reg;

    reg [7:0] mem [0:8183];
    reg [7:0] ctrl_reg;
    reg [7:0] vis_reg [0:6];
    reg [7:0] cnt_reg [0:6];
    reg stop_reg, probe_reg, probe_phase_reg, set_d_reg;
    reg [24:0] sec_div_reg;
    reg [14:0] probe_div_reg;
    reg pend_reg;

    wire sel_ok = !sel_b && select_hi && !below_fail_threshold;
    wire is_clk = (addr[12:3] == `BTK_CLK_AREA);
    wire do_wr = sel_ok && !wr_b;
    wire do_rd = sel_ok && wr_b;
    wire host_busy = sel_ok;
    wire halted = ctrl_reg[`BTK_CTRL_SET_BIT];
    wire frozen = ctrl_reg[`BTK_CTRL_FREEZE_BIT] || halted;
    wire [2:0] ci = addr[2:0] - 3'd1;

    // leap year: year of century divisible by four, bcd
    wire [7:0] yr = cnt_reg[6];
    wire leap = (yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00));
    reg [7:0] mlen;
    always @* begin
        case (cnt_reg[5])
            8'h02: mlen = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mlen = 8'h30;
            default: mlen = 8'h31;
        endcase
    end

    wire [7:0] n_s, n_m, n_h, n_w, n_d, n_mo, n_y;
    wire c_s, c_m, c_h, c_d, c_mo;
    btk_bcd_digit u_s (.cur({1'b0, cnt_reg[0][6:0]}), .lo(8'h00), .hi(8'h59), .nxt(n_s), .carry(c_s));
    btk_bcd_digit u_m (.cur(cnt_reg[1]), .lo(8'h00), .hi(8'h59), .nxt(n_m), .carry(c_m));
    btk_bcd_digit u_h (.cur(cnt_reg[2]), .lo(8'h00), .hi(8'h23), .nxt(n_h), .carry(c_h));
    btk_bcd_digit u_w (.cur({5'h00, cnt_reg[3][2:0]}), .lo(8'h01), .hi(8'h07), .nxt(n_w), .carry());
    btk_bcd_digit u_d (.cur(cnt_reg[4]), .lo(8'h01), .hi(mlen), .nxt(n_d), .carry(c_d));
    btk_bcd_digit u_mo (.cur(cnt_reg[5]), .lo(8'h01), .hi(8'h12), .nxt(n_mo), .carry(c_mo));
    btk_bcd_digit u_y (.cur(cnt_reg[6]), .lo(8'h00), .hi(8'h99), .nxt(n_y), .carry());

    wire sec_tick = (sec_div_reg == SEC_DIV - 1) && !stop_reg && !halted;
    integer i;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= 8'h00;
            stop_reg <= 1'b0;
            probe_reg <= 1'b0;
            probe_phase_reg <= 1'b0;
            set_d_reg <= 1'b0;
            sec_div_reg <= 25'h0000000;
            probe_div_reg <= 15'h0000;
            pend_reg <= 1'b0;
            for (i = 0; i < 7; i = i + 1) begin
                vis_reg[i] <= 8'h00;
                cnt_reg[i] <= 8'h00;
            end
            cnt_reg[3] <= 8'h01;
            cnt_reg[4] <= 8'h01;
            cnt_reg[5] <= 8'h01;
        end else begin
            set_d_reg <= halted;
            // oscillator stop halts the divider entirely
            if (!stop_reg) begin
                sec_div_reg <= (sec_div_reg == SEC_DIV - 1) ? 25'h0000000 : sec_div_reg + 25'h0000001;
                probe_div_reg <= (probe_div_reg == PROBE_DIV - 1) ? 15'h0000 : probe_div_reg + 15'h0001;
                if (probe_div_reg == PROBE_DIV - 1)
                    probe_phase_reg <= ~probe_phase_reg;
            end
            if (sec_tick) begin
                cnt_reg[0] <= n_s;
                if (c_s) cnt_reg[1] <= n_m;
                if (c_s && c_m) cnt_reg[2] <= n_h;
                if (c_s && c_m && c_h) begin
                    cnt_reg[3] <= n_w;
                    cnt_reg[4] <= n_d;
                    if (c_d) cnt_reg[5] <= n_mo;
                    if (c_d && c_mo) cnt_reg[6] <= n_y;
                end
            end
            // set released: loaded values go into the counters
            if (set_d_reg && !halted) begin
                for (i = 0; i < 7; i = i + 1)
                    cnt_reg[i] <= vis_reg[i];
                cnt_reg[0] <= {1'b0, vis_reg[0][6:0]};
                cnt_reg[3] <= {5'h00, vis_reg[3][2:0]};
                sec_div_reg <= 25'h0000000;
            end
            // refresh only while an update is pending (tick, set release, freeze clear) and never under a live access
            if (pend_reg && !frozen && !host_busy) begin
                pend_reg <= 1'b0;
                for (i = 0; i < 7; i = i + 1)
                    vis_reg[i] <= cnt_reg[i];
                vis_reg[0] <= {stop_reg, cnt_reg[0][6:0]};
                vis_reg[3] <= {1'b0, probe_reg, 3'h0, cnt_reg[3][2:0]};
            end
            // a tick in the refresh cycle must win, else that second stays unseen
            if (sec_tick || (set_d_reg && !halted))
                pend_reg <= 1'b1;
            if (do_wr && is_clk) begin
                if (addr[2:0] == 3'd0) begin
                    ctrl_reg <= dq_in;
                    if (ctrl_reg[`BTK_CTRL_FREEZE_BIT] && !dq_in[`BTK_CTRL_FREEZE_BIT])
                        pend_reg <= 1'b1;
                end else begin
                    vis_reg[ci] <= dq_in;
                    if (addr == `BTK_SEC_ADDR) stop_reg <= dq_in[`BTK_STOP_BIT];
                    if (addr == `BTK_DAY_ADDR) probe_reg <= dq_in[`BTK_PROBE_BIT];
                end
            end
        end
    end

    always @(posedge clock) begin
        if (do_wr && !is_clk)
            mem[addr] <= dq_in;
    end

    // probe replaces seconds bit 0 on reads while running
    reg [7:0] rd_data;
    always @* begin
        rd_data = 8'h00;
        if (!is_clk)
            rd_data = mem[addr];
        else if (addr[2:0] == 3'd0)
            rd_data = ctrl_reg;
        else
            rd_data = vis_reg[ci];
        if (addr == `BTK_SEC_ADDR && probe_reg && !stop_reg)
            rd_data = {rd_data[7:1], probe_phase_reg};
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= 8'h00;
            dq_oe_b <= 1'b1;
            fail_rst_out <= 1'b0;
            fail_rst_oe_b <= 1'b1;
            battery_connect <= 1'b0;
            on_battery <= 1'b0;
        end else begin
            dq_out <= rd_data;
            dq_oe_b <= !(do_rd && !out_en_b);
            fail_rst_oe_b <= !below_fail_threshold;
            if (!below_fail_threshold) battery_connect <= 1'b1;
            on_battery <= battery_connect && below_battery;
        end
    end
endmodule // btk_clock_sram

// ==== bench/btk_clock_sram_properties.sv ====
// concurrent checks on the pins of the timekeeping sram clock
`timescale 1ns/100ps
module btk_clock_sram_props #(
    parameter SEC_DIV = 50,
    parameter PROBE_DIV = 4
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // host sram port
    input wire [12:0] addr,
    input wire sel_b,
    input wire select_hi,
    input wire out_en_b,
    input wire wr_b,
    input wire [7:0] dq_in,
    input wire [7:0] dq_out,
    input wire dq_oe_b,
    // supply monitor
    input wire below_fail_threshold,
    input wire below_battery,
    // power-fail reset and battery switch
    input wire fail_rst_out,
    input wire fail_rst_oe_b,
    input wire battery_connect,
    input wire on_battery
);
    // internal reset lags the pin by two edges, so reads count only after that
    reg [1:0] live_cnt;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) live_cnt <= 2'h0;
        else if (live_cnt != 2'h3) live_cnt <= live_cnt + 2'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence read_req;
        !sel_b && select_hi && wr_b && !out_en_b && !below_fail_threshold;
    endsequence
    // outputs still show reset values for two edges after the pin rises
    sequence fail_held;
        (live_cnt == 2'h3) ##0 below_fail_threshold ##1 below_fail_threshold;
    endsequence
    chk_read_drives: assert property ((live_cnt == 2'h3) ##0 read_req |=> !dq_oe_b)
        else $error("read cycle left data released");
    chk_oe_off_release: assert property (out_en_b |=> dq_oe_b)
        else $error("data driven with drive enable off");
    chk_deselect_release: assert property ((sel_b || !select_hi) |=> dq_oe_b)
        else $error("data driven while deselected");
    chk_write_release: assert property ((!wr_b && !sel_b) |=> dq_oe_b)
        else $error("data driven during write");
    chk_fail_blocks: assert property (below_fail_threshold |=> dq_oe_b)
        else $error("access allowed in supply fail");
    chk_fail_reset_low: assert property (fail_held |-> !fail_rst_oe_b)
        else $error("fail reset not pulled low");
    chk_fail_reset_free: assert property (!below_fail_threshold [*3] |-> fail_rst_oe_b)
        else $error("fail reset held with good supply");
    chk_fail_open_drain: assert property (fail_rst_out == 1'b0)
        else $error("fail reset drives high");
    chk_battery_wait: assert property ((!battery_connect && below_fail_threshold) |=> !battery_connect)
        else $error("battery joined before good supply");
    chk_battery_sticky: assert property (battery_connect |=> battery_connect)
        else $error("battery disconnected again");
    chk_backup_switch: assert property ((battery_connect && below_battery) |=> on_battery)
        else $error("no switch to battery on low supply");
endmodule // btk_clock_sram_props
bind btk_clock_sram btk_clock_sram_props #(.SEC_DIV(SEC_DIV), .PROBE_DIV(PROBE_DIV)) i_props (.clock(clock),
    .rst_b(rst_b), .addr(addr), .sel_b(sel_b), .select_hi(select_hi), .out_en_b(out_en_b), .wr_b(wr_b),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .below_fail_threshold(below_fail_threshold),
    .below_battery(below_battery), .fail_rst_out(fail_rst_out), .fail_rst_oe_b(fail_rst_oe_b),
    .battery_connect(battery_connect), .on_battery(on_battery));

// ==== bench/btk_host.sv ====
// host model: asynchronous sram bus master doing byte writes and reads
`timescale 1ns/100ps
module btk_host (
    // clock
    input wire clock,
    // sram bus
    output logic [12:0] addr,
    output logic sel_b,
    output logic select_hi,
    output logic out_en_b,
    output logic wr_b,
    output logic [7:0] dq_in,
    input wire [7:0] dq_out,
    input wire dq_oe_b
);
    initial begin
        addr = 13'h0000;
        sel_b = 1'b1;
        select_hi = 1'b1;
        out_en_b = 1'b1;
        wr_b = 1'b1;
        dq_in = 8'h00;
    end
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        addr = a;
        dq_in = d;
        sel_b = 1'b0;
        wr_b = 1'b0;
        @(posedge clock) #1;
        wr_b = 1'b1;
        sel_b = 1'b1;
        // stale write data is not left on the lines
        dq_in = ~d;
    endtask
    task automatic rd(input logic [12:0] a, input logic hi, output logic [7:0] d, output logic oe_b);
        @(posedge clock) #1;
        addr = a;
        select_hi = hi;
        sel_b = 1'b0;
        out_en_b = 1'b0;
        @(posedge clock) #1;
        d = dq_out;
        oe_b = dq_oe_b;
        sel_b = 1'b1;
        out_en_b = 1'b1;
        select_hi = 1'b1;
    endtask
endmodule // btk_host

// ==== bench/test_btk_clock_sram.sv ====
// self-checking bench for the timekeeping sram clock
`timescale 1ns/100ps
`include "btk_map.vh"
module test_btk_clock_sram;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic fail = 1'b1;
    logic batt = 1'b1;
    logic oe;
    logic [7:0] d, s0;
    wire [12:0] addr;
    wire sel_b, select_hi, out_en_b, wr_b, dq_oe_b, froe, bc, ob;
    int ones = 0;
    wire [7:0] dq_in, dq_out;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // time and date bytes in bcd, unused bits zero, hours in 24-hour form
    logic [20:0] rows [11] = '{{13'h0000, 8'h5a}, {13'h1ff7, 8'ha5}, {13'h0abc, 8'h3c}, {`BTK_CTRL_ADDR, 8'h80},
        {`BTK_YEAR_ADDR, 8'h04}, {`BTK_MONTH_ADDR, 8'h02}, {`BTK_DATE_ADDR, 8'h28}, {`BTK_DAY_ADDR, 8'h07},
        {`BTK_HOUR_ADDR, 8'h23}, {`BTK_MIN_ADDR, 8'h59}, {`BTK_SEC_ADDR, 8'h59}};
    logic [7:0] after_tick [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04};
    btk_host i_host (.clock, .addr, .sel_b, .select_hi, .out_en_b, .wr_b, .dq_in, .dq_out, .dq_oe_b);
    btk_clock_sram #(.SEC_DIV(50), .PROBE_DIV(4)) i_dut (.clock, .rst_b, .addr, .sel_b, .select_hi,
        .out_en_b, .wr_b, .dq_in, .dq_out, .dq_oe_b, .below_fail_threshold(fail), .below_battery(batt),
        .fail_rst_out(), .fail_rst_oe_b(froe), .battery_connect(bc), .on_battery(ob));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d of %0d compares", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge clock);
        #1 cmp({6'h00, bc, ob}, 8'h00);
        fail = 1'b0;
        batt = 1'b0;
        repeat (3) @(posedge clock);
        #1 cmp({7'h00, bc}, 8'h01);
        foreach (rows[i]) begin
            i_host.wr(rows[i][20:8], rows[i][7:0]);
            i_host.rd(rows[i][20:8], 1'b1, d, oe);
            cmp(d, rows[i][7:0]);
        end
        i_host.wr(`BTK_CTRL_ADDR, 8'h00);
        d = 8'h59;
        for (int k = 0; k < 150 && d !== 8'h00; k++) i_host.rd(`BTK_SEC_ADDR, 1'b1, d, oe);
        for (int i = 0; i < 7; i++) begin
            i_host.rd(`BTK_SEC_ADDR + 13'(i), 1'b1, d, oe);
            cmp(d, after_tick[i]);
        end
        i_host.wr(`BTK_CTRL_ADDR, 8'h40);
        i_host.rd(`BTK_SEC_ADDR, 1'b1, s0, oe);
        repeat (120) @(posedge clock);
        i_host.rd(`BTK_SEC_ADDR, 1'b1, d, oe);
        cmp(d, s0);
        i_host.wr(`BTK_CTRL_ADDR, 8'h00);
        repeat (3) @(posedge clock);
        i_host.rd(`BTK_SEC_ADDR, 1'b1, d, oe);
        // counters ran on while frozen: two or three ticks of fifty cycles have passed
        cmp({7'h00, d == s0 + 8'h02 || d == s0 + 8'h03}, 8'h01);
        i_host.wr(`BTK_CTRL_ADDR, 8'h80);
        i_host.wr(`BTK_SEC_ADDR, 8'h80);
        i_host.wr(`BTK_DAY_ADDR, 8'h41);
        i_host.wr(`BTK_CTRL_ADDR, 8'h00);
        repeat (120) @(posedge clock);
        i_host.rd(`BTK_SEC_ADDR, 1'b1, d, oe);
        cmp(d, 8'h80);
        i_host.rd(`BTK_DAY_ADDR, 1'b1, d, oe);
        cmp(d, 8'h41);
        i_host.wr(`BTK_SEC_ADDR, 8'h00);
        // reads land every two cycles and the probe toggles every four: two of four read high
        for (int k = 0; k < 4; k++) begin
            i_host.rd(`BTK_SEC_ADDR, 1'b1, d, oe);
            ones += d[0];
        end
        cmp(8'(ones), 8'h02);
        i_host.rd(13'h0000, 1'b0, d, oe);
        cmp({7'h00, oe}, 8'h01);
        fail = 1'b1;
        batt = 1'b1;
        i_host.wr(13'h0000, 8'h00);
        i_host.rd(13'h0000, 1'b1, d, oe);
        cmp({7'h00, oe}, 8'h01);
        cmp({7'h00, froe}, 8'h00);
        cmp({7'h00, ob}, 8'h01);
        fail = 1'b0;
        batt = 1'b0;
        repeat (4) @(posedge clock);
        #1 cmp({7'h00, froe}, 8'h01);
        cmp({7'h00, ob}, 8'h00);
        i_host.rd(13'h0000, 1'b1, d, oe);
        cmp(d, 8'h5a);
        tally_and_finish;
    end
endmodule // test_btk_clock_sram
